// ### design/pdpr_pkg.sv
// Shared constants and helpers for the pseudo dual-port block memory
package pdpr_pkg;

  // Storage of one block and the two width families
  localparam int unsigned BLOCK_BITS  = 18432;
  localparam int unsigned NARROW_BITS = 16384;
  localparam int unsigned WIDE_STEP   = 9;

  // Block select
  localparam int unsigned CS_W       = 3;
  localparam logic [2:0]  CS_DEFAULT = 3'h0;

  // Register byte offsets on the bus
  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_WCOUNT = 8'h08;
  localparam logic [7:0] OFS_RCOUNT = 8'h0c;
  localparam int unsigned OFS_W     = 8;

  // Control register fields
  localparam int unsigned CTRL_OUT_REG_BIT = 0;
  localparam int unsigned CTRL_RDCS_LSB    = 4;
  localparam int unsigned CTRL_WRCS_LSB    = 8;
  localparam logic        OUT_REG_DEFAULT  = 1'b0;

  // Status register fields
  localparam int unsigned STAT_RDHIT_BIT = 0;
  localparam int unsigned STAT_WRHIT_BIT = 1;

  // Access counters
  localparam int unsigned CNT_W = 16;

  // Bus encodings
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic       HRESP_OKAY    = 1'b0;
  localparam int unsigned HTRANS_ACTIVE_BIT = 1;

  // Output register choice
  typedef enum logic {
    PDPR_UNREGISTERED_OUTPUT,
    PDPR_REGISTERED_OUTPUT
  } pdpr_out_mode_e;

  // True for the six supported port widths
  function automatic bit width_ok(input int unsigned w);
    width_ok = (w == 1) || (w == 2) || (w == 4) || (w == 9) || (w == 18) || (w == 36);
  endfunction : width_ok

  // True when the width uses the full block including the ninth bits
  function automatic bit wide_family(input int unsigned w);
    wide_family = (w % WIDE_STEP) == 0;
  endfunction : wide_family

  // Words of the given width that one block holds
  function automatic int unsigned block_depth(input int unsigned w);
    block_depth = wide_family(w) ? (BLOCK_BITS / w) : (NARROW_BITS / w);
  endfunction : block_depth

endpackage : pdpr_pkg

// ### design/pdpr_pseudo_dual_port_ram.sv
// Pseudo dual-port block memory with bus-visible configuration and status
// Behaviour
// - Write data, write address and read address are registered before the array.
// - Read data unregistered by default, or through one extra output register.
// - Reset clears port, bus, counter and configuration registers; stored contents are kept.
// - Each port has a 3-bit block select acting as top address bits.
// - One block holds 18,432 bits; the 9, 18 and 36 wide shapes use all of them, the 1, 2 and 4 wide shapes 16,384.
// - Shapes 16Kx1 up to 512x36; address widths follow the depth.
// - Read and write widths chosen from 1, 2, 4, 9, 18, 36; default 1.
// - Both ports use normal write mode only.
// - Each port has a 3-bit select decode value, default zero, must match.
// - Small memories fit one block; larger ones cascade blocks outside.
`timescale 1ns/1ps
module pdpr_pseudo_dual_port_ram
  import pdpr_pkg::*;
#(
  parameter int unsigned READ_W       = 1,
  parameter int unsigned WRITE_W      = 1,
  parameter logic        INIT_BIT     = 1'b0,
  parameter bit          SET_RESET_EN = 1'b1,
  parameter int unsigned WA_W         = $clog2(block_depth(WRITE_W)),
  parameter int unsigned RA_W         = $clog2(block_depth(READ_W))
)
(
  input  wire logic               clock_i,
  input  wire logic               rst_i,
  // Write port
  input  wire logic [WA_W-1:0]    write_addr_i,
  input  wire logic [WRITE_W-1:0] write_data_i,
  input  wire logic               write_en_i,
  input  wire logic               write_clk_en_i,
  input  wire logic [CS_W-1:0]    write_cs_i,
  // Read port
  input  wire logic [RA_W-1:0]    read_addr_i,
  input  wire logic               read_clk_en_i,
  input  wire logic [CS_W-1:0]    read_cs_i,
  output logic      [READ_W-1:0]  read_data_o,
  // AHB-Lite slave
  input  wire logic               hsel_i,
  input  wire logic [31:0]        haddr_i,
  input  wire logic [1:0]         htrans_i,
  input  wire logic               hwrite_i,
  input  wire logic [2:0]         hsize_i,
  input  wire logic               hready_i,
  input  wire logic [31:0]        hwdata_i,
  output logic      [31:0]        hrdata_o,
  output logic                    hreadyout_o,
  output logic                    hresp_o
);

  // One storage unit is the narrower port width
  localparam int unsigned UNIT_W = (READ_W < WRITE_W) ? READ_W : WRITE_W;

  // Refuse shapes the array cannot serve
  initial
  begin
    if (!width_ok(READ_W) || !width_ok(WRITE_W))
      $error("Port width must be 1, 2, 4, 9, 18 or 36");
    if (wide_family(READ_W) != wide_family(WRITE_W))
      $error("Port widths must both use or both skip the ninth bits");
    if ((READ_W % UNIT_W) != 0 || (WRITE_W % UNIT_W) != 0)
      $error("Port widths must be integer multiples of each other");
    if (WA_W != $clog2(block_depth(WRITE_W)) || RA_W != $clog2(block_depth(READ_W)))
      $error("Address widths must follow the chosen depths");
  end

  // Block select match, shared by both ports
  function automatic logic cs_hit(input logic [CS_W-1:0] sel, input logic [CS_W-1:0] code);
    cs_hit = (sel == code);
  endfunction : cs_hit

  // Port register reset only acts while the global set/reset connection is enabled
  logic port_reset;
  assign port_reset = rst_i & SET_RESET_EN;

  // Configuration state
  logic           out_reg_en;
  logic [CS_W-1:0] read_cs_code;
  logic [CS_W-1:0] write_cs_code;
  pdpr_out_mode_e out_mode;

  assign out_mode = out_reg_en ? PDPR_REGISTERED_OUTPUT : PDPR_UNREGISTERED_OUTPUT;

  // Write input registers
  logic [WA_W-1:0]    prim_write_addr;
  logic [WRITE_W-1:0] prim_write_data;
  logic               write_pending;
  logic [WA_W-1:0]    next_prim_write_addr;
  logic [WRITE_W-1:0] next_prim_write_data;
  logic               next_write_pending;

  // Capture the write port on its enable; store only on a select match
  always_comb
  begin
    next_prim_write_addr = prim_write_addr;
    next_prim_write_data = prim_write_data;
    next_write_pending   = 1'b0;
    if (write_clk_en_i)
    begin
      next_prim_write_addr = write_addr_i;
      next_prim_write_data = write_data_i;
      next_write_pending   = write_en_i & cs_hit(write_cs_i, write_cs_code);
    end
  end

  always_ff @(posedge clock_i)
  begin
    if (port_reset)
    begin
      prim_write_addr <= '0;
      prim_write_data <= '0;
      write_pending   <= 1'b0;
    end
    else
    begin
      prim_write_addr <= next_prim_write_addr;
      prim_write_data <= next_prim_write_data;
      write_pending   <= next_write_pending;
    end
  end

  // Read input registers
  logic [RA_W-1:0] prim_read_addr;
  logic            read_hit;
  logic [RA_W-1:0] next_prim_read_addr;
  logic            next_read_hit;

  // Address and select latched together so data follows one access
  always_comb
  begin
    next_prim_read_addr = prim_read_addr;
    next_read_hit       = read_hit;
    if (read_clk_en_i)
    begin
      next_prim_read_addr = read_addr_i;
      next_read_hit       = cs_hit(read_cs_i, read_cs_code);
    end
  end

  always_ff @(posedge clock_i)
  begin
    if (port_reset)
    begin
      prim_read_addr <= '0;
      read_hit       <= 1'b0;
    end
    else
    begin
      prim_read_addr <= next_prim_read_addr;
      read_hit       <= next_read_hit;
    end
  end

  // Array
  logic [READ_W-1:0] fetch_data;
  logic [READ_W-1:0] read_data_bits;

  pdpr_storage #(
    .UNIT_W   (UNIT_W),
    .WRITE_W  (WRITE_W),
    .READ_W   (READ_W),
    .INIT_BIT (INIT_BIT),
    .WA_W     (WA_W),
    .RA_W     (RA_W)
  ) u_storage (
    .clock_i      (clock_i),
    .store_i      (write_pending),
    .store_addr_i (prim_write_addr),
    .store_data_i (prim_write_data),
    .fetch_addr_i (prim_read_addr),
    .fetch_data_o (fetch_data)
  );

  // Unselected block drives zeros so cascaded outputs can be ORed
  assign read_data_bits = read_hit ? fetch_data : '0;

  // Optional output register stage
  logic [READ_W-1:0] out_data;
  logic [READ_W-1:0] next_out_data;

  always_comb
  begin
    next_out_data = out_data;
    if (read_clk_en_i)
      next_out_data = read_data_bits;
  end

  always_ff @(posedge clock_i)
  begin
    if (port_reset)
      out_data <= '0;
    else
      out_data <= next_out_data;
  end

  // Mode may change on the fly; the first word after a change can be stale
  always_comb
  begin
    case (out_mode)
      PDPR_REGISTERED_OUTPUT:   read_data_o = out_data;
      PDPR_UNREGISTERED_OUTPUT: read_data_o = read_data_bits;
      default:                  read_data_o = read_data_bits;
    endcase
  end

  // Bus address phase decode
  logic             bus_take;
  logic             bus_wr_pending;
  logic [OFS_W-1:0] bus_ofs;
  logic             next_bus_wr_pending;
  logic [OFS_W-1:0] next_bus_ofs;
  logic [31:0]      next_hrdata;
  logic             wcount_clear;
  logic             rcount_clear;

  assign bus_take     = hsel_i & htrans_i[HTRANS_ACTIVE_BIT] & hready_i;
  assign wcount_clear = bus_wr_pending & (bus_ofs == OFS_WCOUNT);
  assign rcount_clear = bus_wr_pending & (bus_ofs == OFS_RCOUNT);

  // Access counters, status for software
  logic [CNT_W-1:0] write_count;
  logic [CNT_W-1:0] read_count;
  logic             read_strobe;
  logic [CNT_W-1:0] next_write_count;
  logic [CNT_W-1:0] next_read_count;

  assign read_strobe = read_clk_en_i & cs_hit(read_cs_i, read_cs_code);

  // An access in the clearing cycle still counts
  always_comb
  begin
    next_write_count = wcount_clear ? '0 : write_count;
    next_read_count  = rcount_clear ? '0 : read_count;
    if (write_pending)
      next_write_count = CNT_W'(next_write_count + CNT_W'(1));
    if (read_strobe)
      next_read_count = CNT_W'(next_read_count + CNT_W'(1));
  end

  always_ff @(posedge clock_i)
  begin
    if (rst_i)
    begin
      write_count <= '0;
      read_count  <= '0;
    end
    else
    begin
      write_count <= next_write_count;
      read_count  <= next_read_count;
    end
  end

  // Read data prepared at the address phase so there is no wait state
  always_comb
  begin
    next_bus_wr_pending = 1'b0;
    next_bus_ofs        = bus_ofs;
    next_hrdata         = hrdata_o;
    if (bus_take)
    begin
      next_bus_wr_pending = hwrite_i;
      next_bus_ofs        = haddr_i[OFS_W-1:0];
      next_hrdata         = '0;
      if (!hwrite_i)
      begin
        case (haddr_i[OFS_W-1:0])
          OFS_CTRL:
          begin
            next_hrdata[CTRL_OUT_REG_BIT]               = out_reg_en;
            next_hrdata[CTRL_RDCS_LSB +: CS_W]          = read_cs_code;
            next_hrdata[CTRL_WRCS_LSB +: CS_W]          = write_cs_code;
          end
          OFS_STATUS:
          begin
            next_hrdata[STAT_RDHIT_BIT] = read_hit;
            next_hrdata[STAT_WRHIT_BIT] = write_pending;
          end
          OFS_WCOUNT: next_hrdata[CNT_W-1:0] = write_count;
          OFS_RCOUNT: next_hrdata[CNT_W-1:0] = read_count;
          default:    next_hrdata = '0;
        endcase
      end
    end
  end

  always_ff @(posedge clock_i)
  begin
    if (rst_i)
    begin
      bus_wr_pending <= 1'b0;
      bus_ofs        <= '0;
      hrdata_o       <= '0;
    end
    else
    begin
      bus_wr_pending <= next_bus_wr_pending;
      bus_ofs        <= next_bus_ofs;
      hrdata_o       <= next_hrdata;
    end
  end

  // Control register, written in the data phase
  logic            next_out_reg_en;
  logic [CS_W-1:0] next_read_cs_code;
  logic [CS_W-1:0] next_write_cs_code;

  always_comb
  begin
    next_out_reg_en    = out_reg_en;
    next_read_cs_code  = read_cs_code;
    next_write_cs_code = write_cs_code;
    if (bus_wr_pending && (bus_ofs == OFS_CTRL))
    begin
      next_out_reg_en    = hwdata_i[CTRL_OUT_REG_BIT];
      next_read_cs_code  = hwdata_i[CTRL_RDCS_LSB +: CS_W];
      next_write_cs_code = hwdata_i[CTRL_WRCS_LSB +: CS_W];
    end
  end

  // Configuration is bus state, not a port register, so the plain reset clears it
  always_ff @(posedge clock_i)
  begin
    if (rst_i)
    begin
      out_reg_en    <= OUT_REG_DEFAULT;
      read_cs_code  <= CS_DEFAULT;
      write_cs_code <= CS_DEFAULT;
    end
    else
    begin
      out_reg_en    <= next_out_reg_en;
      read_cs_code  <= next_read_cs_code;
      write_cs_code <= next_write_cs_code;
    end
  end

  // Zero wait states, always OKAY
  assign hreadyout_o = 1'b1;
  assign hresp_o     = HRESP_OKAY;

endmodule : pdpr_pseudo_dual_port_ram

// ### design/pdpr_storage.sv
// Storage array of one block, kept in flip-flops, never reset
`timescale 1ns/1ps
module pdpr_storage
  import pdpr_pkg::*;
#(
  parameter int unsigned UNIT_W   = 1,
  parameter int unsigned WRITE_W  = 1,
  parameter int unsigned READ_W   = 1,
  parameter logic        INIT_BIT = 1'b0,
  parameter int unsigned WA_W     = $clog2(block_depth(WRITE_W)),
  parameter int unsigned RA_W     = $clog2(block_depth(READ_W))
)
(
  input  wire logic              clock_i,
  input  wire logic              store_i,
  input  wire logic [WA_W-1:0]   store_addr_i,
  input  wire logic [WRITE_W-1:0] store_data_i,
  input  wire logic [RA_W-1:0]   fetch_addr_i,
  output logic      [READ_W-1:0] fetch_data_o
);

  localparam int unsigned UNITS    = block_depth(UNIT_W);
  localparam int unsigned UA_W     = $clog2(UNITS);
  localparam int unsigned WR_RATIO = WRITE_W / UNIT_W;
  localparam int unsigned RD_RATIO = READ_W / UNIT_W;

  // Initial pattern; reset never touches the cells
  logic [UNIT_W-1:0] cells [UNITS] = '{default: {UNIT_W{INIT_BIT}}};
  logic [UA_W-1:0]   store_idx [WR_RATIO];
  logic [UA_W-1:0]   fetch_base;

  // Unit indices covered by the write word
  always_comb
  begin
    for (int k = 0; k < WR_RATIO; k++)
    begin
      store_idx[k] = UA_W'(UA_W'(store_addr_i) * UA_W'(WR_RATIO) + UA_W'(k));
    end
  end

  // Normal write: the stored word only, no read side effect
  always_ff @(posedge clock_i)
  begin
    if (store_i)
    begin
      for (int k = 0; k < WR_RATIO; k++)
      begin
        cells[store_idx[k]] <= store_data_i[k*UNIT_W +: UNIT_W];
      end
    end
  end

  // Read word assembled from consecutive units, lowest unit in low bits
  assign fetch_base = UA_W'(UA_W'(fetch_addr_i) * UA_W'(RD_RATIO));

  for (genvar g = 0; g < RD_RATIO; g++)
  begin : g_fetch
    assign fetch_data_o[g*UNIT_W +: UNIT_W] = cells[UA_W'(fetch_base + UA_W'(g))];
  end

endmodule : pdpr_storage

// ### test/pdpr_fabric_model.sv
// Fabric-side user logic driving the memory's write and read ports
`timescale 1ns/1ps
module pdpr_fabric_model #(
  parameter int unsigned W  = 4,
  parameter int unsigned AW = 12
)
(
  input  wire logic          clock_i,
  input  wire logic [W-1:0]  read_data_i,
  output logic      [AW-1:0] write_addr_o,
  output logic      [W-1:0]  write_data_o,
  output logic               write_en_o,
  output logic               write_clk_en_o,
  output logic      [2:0]    write_cs_o,
  output logic      [AW-1:0] read_addr_o,
  output logic               read_clk_en_o,
  output logic      [2:0]    read_cs_o
);
  // Idle at time zero
  initial
  begin
    {write_addr_o, write_data_o, write_en_o, write_clk_en_o, write_cs_o} = '0;
    {read_addr_o, read_clk_en_o, read_cs_o} = '0;
  end
  // One write, then a spare edge so the store has landed
  task automatic wr(input logic [AW-1:0] a, input logic [W-1:0] d, input logic [2:0] cs,
                    input logic we, input logic ce);
    @(posedge clock_i);
    write_addr_o <= a;
    write_data_o <= d;
    write_cs_o <= cs;
    write_en_o <= we;
    write_clk_en_o <= ce;
    @(posedge clock_i);
    write_en_o <= 1'b0;
    write_clk_en_o <= 1'b0;
    write_data_o <= ~d; // Released lines show changed values
    write_addr_o <= ~a;
    write_cs_o <= ~cs;
    @(posedge clock_i);
  endtask : wr
  // Enable held for n edges; data taken once the last edge settled
  task automatic rd(input logic [AW-1:0] a, input logic [2:0] cs, input int n,
                    output logic [W-1:0] d);
    @(posedge clock_i);
    read_addr_o <= a;
    read_cs_o <= cs;
    read_clk_en_o <= 1'b1;
    repeat (n) @(posedge clock_i);
    read_clk_en_o <= 1'b0;
    read_addr_o <= ~a; // Must be ignored while the enable is low
    read_cs_o <= ~cs;
    #1 d = read_data_i;
  endtask : rd
endmodule : pdpr_fabric_model

// ### test/pdpr_pseudo_dual_port_ram_tb.sv
// Self-checking bench for the pseudo dual-port block memory
`timescale 1ns/1ps
module pdpr_pseudo_dual_port_ram_tb;
  import pdpr_pkg::*;
  logic        clock_i = 1'b0;
  logic        rst_i = 1'b1;
  logic [11:0] wa, ra;
  logic [3:0]  wd, rdata, r4;
  logic        we, wce, rce, hready, hresp;
  logic [2:0]  wcs, rcs;
  logic        hsel = 1'b0, hwrite = 1'b0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, r;
  logic [1:0]  htrans = 2'h0;
  logic [11:0] adr [3] = '{12'h000, 12'h001, 12'hfff};
  logic [3:0]  dat [3] = '{4'h9, 4'h6, 4'hc};
  int          num_errors = 0;
  int          n_checks = 0;
  always #2.5 clock_i = ~clock_i;
  pdpr_pseudo_dual_port_ram #(.READ_W(4), .WRITE_W(4)) u_pdpr_pseudo_dual_port_ram (
    .clock_i(clock_i), .rst_i(rst_i), .write_addr_i(wa), .write_data_i(wd),
    .write_en_i(we), .write_clk_en_i(wce), .write_cs_i(wcs), .read_addr_i(ra),
    .read_clk_en_i(rce), .read_cs_i(rcs), .read_data_o(rdata), .hsel_i(hsel),
    .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'h2),
    .hready_i(hready), .hwdata_i(hwdata), .hrdata_o(hrdata), .hreadyout_o(hready),
    .hresp_o(hresp));
  pdpr_fabric_model #(.W(4), .AW(12)) u_pdpr_fabric_model (
    .clock_i(clock_i), .read_data_i(rdata), .write_addr_o(wa), .write_data_o(wd),
    .write_en_o(we), .write_clk_en_o(wce), .write_cs_o(wcs), .read_addr_o(ra),
    .read_clk_en_o(rce), .read_cs_o(rcs));
  task automatic report_and_stop;
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : report_and_stop
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      num_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // Bounded wait for hready at a rising edge
  task automatic wait_rdy;
    for (int k = 0; hready !== 1'b1; k++)
    begin
      if (k > 50)
      begin
        num_errors++;
        report_and_stop;
      end
      @(posedge clock_i);
    end
  endtask : wait_rdy
  // One single AHB-Lite word transfer, address phase then data phase
  task automatic ahb(input logic [31:0] a, input logic w, input logic [31:0] wv,
                     output logic [31:0] rv);
    @(posedge clock_i);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= HTRANS_NONSEQ;
    @(posedge clock_i);
    wait_rdy;
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wv;
    @(posedge clock_i);
    wait_rdy;
    rv = hrdata;
  endtask : ahb
  // Hang guard
  initial
  begin
    repeat (20000) @(posedge clock_i);
    num_errors++;
    report_and_stop;
  end
  initial
  begin
    repeat (20) @(posedge clock_i);
    rst_i <= 1'b0;
    #1 chk({28'h0, rdata}, 32'h0);
    ahb({24'h0, OFS_CTRL}, 1'b0, 32'h0, r);
    chk(r & 32'h771, 32'h0);
    ahb(32'h10, 1'b0, 32'h0, r);
    chk(r, 32'h0);
    for (int i = 0; i < 3; i++)
      u_pdpr_fabric_model.wr(adr[i], dat[i], 3'h0, 1'b1, 1'b1);
    ahb({24'h0, OFS_WCOUNT}, 1'b0, 32'h0, r);
    chk(r, 32'h3);
    for (int i = 0; i < 3; i++)
    begin
      u_pdpr_fabric_model.rd(adr[i], 3'h0, 1, r4);
      chk({28'h0, r4}, {28'h0, dat[i]});
    end
    // Never written word still holds the initial pattern
    u_pdpr_fabric_model.rd(12'h002, 3'h0, 1, r4);
    chk({28'h0, r4}, 32'h0);
    // Refused stores: no enable, no clock enable, wrong select
    u_pdpr_fabric_model.wr(adr[0], 4'h3, 3'h0, 1'b0, 1'b1);
    u_pdpr_fabric_model.wr(adr[0], 4'h3, 3'h0, 1'b1, 1'b0);
    u_pdpr_fabric_model.wr(adr[0], 4'h3, 3'h2, 1'b1, 1'b1);
    u_pdpr_fabric_model.rd(adr[0], 3'h0, 1, r4);
    chk({28'h0, r4}, {28'h0, dat[0]});
    u_pdpr_fabric_model.rd(adr[0], 3'h2, 1, r4);
    chk({28'h0, r4}, 32'h0);
    ahb({24'h0, OFS_WCOUNT}, 1'b0, 32'h0, r);
    chk(r, 32'h3);
    ahb({24'h0, OFS_CTRL}, 1'b1, 32'h550, r);
    ahb({24'h0, OFS_CTRL}, 1'b0, 32'h0, r);
    chk(r & 32'h771, 32'h550);
    u_pdpr_fabric_model.wr(adr[1], 4'h5, 3'h5, 1'b1, 1'b1);
    u_pdpr_fabric_model.rd(adr[1], 3'h5, 1, r4);
    chk({28'h0, r4}, 32'h5);
    u_pdpr_fabric_model.rd(adr[1], 3'h0, 1, r4);
    chk({28'h0, r4}, 32'h0);
    // Output register: one more enabled edge before new data shows
    ahb({24'h0, OFS_CTRL}, 1'b1, 32'h551, r);
    u_pdpr_fabric_model.rd(adr[1], 3'h5, 2, r4);
    chk({28'h0, r4}, 32'h5);
    u_pdpr_fabric_model.rd(adr[0], 3'h5, 1, r4);
    chk({28'h0, r4}, 32'h5);
    u_pdpr_fabric_model.rd(adr[0], 3'h5, 1, r4);
    chk({28'h0, r4}, {28'h0, dat[0]});
    // Reset in mid-run keeps the stored words
    @(posedge clock_i);
    rst_i <= 1'b1;
    repeat (3) @(posedge clock_i);
    rst_i <= 1'b0;
    #1 chk({28'h0, rdata}, 32'h0);
    ahb({24'h0, OFS_CTRL}, 1'b0, 32'h0, r);
    chk(r & 32'h771, 32'h0);
    u_pdpr_fabric_model.rd(adr[1], 3'h0, 1, r4);
    chk({28'h0, r4}, 32'h5);
    u_pdpr_fabric_model.rd(adr[2], 3'h0, 1, r4);
    chk({28'h0, r4}, {28'h0, dat[2]});
    ahb({24'h0, OFS_RCOUNT}, 1'b0, 32'h0, r);
    chk(r, 32'h2);
    ahb({24'h0, OFS_STATUS}, 1'b0, 32'h0, r);
    chk(r, 32'h1);
    report_and_stop;
  end
endmodule : pdpr_pseudo_dual_port_ram_tb

// ### test/pdpr_ram_props.sv
// Concurrent checks on the pseudo dual-port memory ports
`timescale 1ns/1ps
module pdpr_ram_props
  import pdpr_pkg::*;
#(
  parameter int unsigned READ_W = 1
)
(
  input  wire logic              clock_i,
  input  wire logic              rst_i,
  input  wire logic              write_clk_en_i,
  input  wire logic              read_clk_en_i,
  input  wire logic [CS_W-1:0]   read_cs_i,
  input  wire logic [READ_W-1:0] read_data_o,
  input  wire logic              hsel_i,
  input  wire logic [31:0]       haddr_i,
  input  wire logic [1:0]        htrans_i,
  input  wire logic              hwrite_i,
  input  wire logic              hready_i,
  input  wire logic [31:0]       hwdata_i,
  input  wire logic [31:0]       hrdata_o,
  input  wire logic              hreadyout_o,
  input  wire logic              hresp_o
);
  logic [10:0] ctrl;
  logic [10:0] next_ctrl;
  logic        dp;
  logic        next_dp;
  logic        acc;
  // Shadow of the control register, so checks know mode and decode
  always_comb
  begin
    acc = hsel_i && htrans_i[HTRANS_ACTIVE_BIT] && hready_i;
    next_dp = acc && hwrite_i && (haddr_i[7:0] == OFS_CTRL);
    next_ctrl = dp ? (hwdata_i[10:0] & 11'h771) : ctrl;
  end
  // Cleared with the design, since its control register resets too
  always_ff @(posedge clock_i)
  begin
    if (rst_i)
    begin
      dp <= 1'b0;
      ctrl <= 11'h0;
    end
    else
    begin
      dp <= next_dp;
      ctrl <= next_ctrl;
    end
  end
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (rst_i);
  sequence rd_phase;
    acc && !hwrite_i;
  endsequence
  // No capture on either port and no bus access in a cycle
  sequence quiet_port;
    !read_clk_en_i && !write_clk_en_i && !hsel_i;
  endsequence
  chk_reset_clears: assert property (disable iff (1'b0)
    rst_i |=> read_data_o == '0 && hrdata_o == 32'h0) else $error("reset left data");
  chk_ready_high: assert property (hreadyout_o == 1'b1) else $error("wait state seen");
  chk_resp_okay: assert property (hresp_o == HRESP_OKAY) else $error("error response");
  chk_rdata_holds: assert property (!acc |=> $stable(hrdata_o))
    else $error("read data moved");
  // A write address phase also loads the read data register, with zero
  chk_wphase_zero: assert property (acc && hwrite_i |=> hrdata_o == 32'h0)
    else $error("write phase left read data");
  chk_unmapped_zero: assert property (rd_phase ##0 haddr_i[7:0] > OFS_RCOUNT
    |=> hrdata_o == 32'h0) else $error("unmapped read not zero");
  chk_ctrl_readback: assert property (rd_phase ##0 haddr_i[7:0] == OFS_CTRL && !dp
    |=> (hrdata_o[10:0] & 11'h771) == ctrl) else $error("control readback wrong");
  chk_miss_zero: assert property (read_clk_en_i && read_cs_i != ctrl[6:4]
    && !ctrl[0] && !dp |=> read_data_o == '0) else $error("unselected read not zero");
  chk_read_held: assert property (quiet_port ##1 quiet_port
    |=> $stable(read_data_o)) else $error("read data moved while idle");
  chk_registered_output_holds: assert property (ctrl[0] && !read_clk_en_i && !dp
    |=> $stable(read_data_o)) else $error("output register moved");
endmodule : pdpr_ram_props

bind pdpr_pseudo_dual_port_ram pdpr_ram_props #(.READ_W(READ_W)) u_pdpr_ram_props (
  .clock_i(clock_i), .rst_i(rst_i), .write_clk_en_i(write_clk_en_i),
  .read_clk_en_i(read_clk_en_i), .read_cs_i(read_cs_i), .read_data_o(read_data_o),
  .hsel_i(hsel_i), .haddr_i(haddr_i), .htrans_i(htrans_i), .hwrite_i(hwrite_i),
  .hready_i(hready_i), .hwdata_i(hwdata_i), .hrdata_o(hrdata_o),
  .hreadyout_o(hreadyout_o), .hresp_o(hresp_o));
